// [common/spc_pkg.sv]
// package of constants and carriers for the serial port configuration registers
package spc_pkg;
   localparam int AW = 13;
   localparam logic [12:0] OFF_CONFIG = 13'h0000;
   localparam logic [12:0] OFF_VARIANT = 13'h0003;
   localparam logic [12:0] OFF_READSRC = 13'h0004;
   localparam logic [12:0] OFF_UPDATE = 13'h0232;
   localparam int CFG_SDO_BIT = 0;
   localparam int CFG_LSB_BIT = 1;
   localparam int CFG_RST_BIT = 2;
   localparam int CFG_LONG_BIT = 3;
   localparam int RSRC_ACTIVE_BIT = 0;
   localparam int UPD_BIT = 0;
   localparam logic [7:0] CONFIG_RESET = 8'h18;
   localparam logic [7:0] READSRC_RESET = 8'h00;
   localparam logic [7:0] VARIANT_ID = 8'h2a; // arbitrary value
   localparam int INSTR_BITS = 16;
   typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} spc_state_e;
   typedef struct packed {
      logic sclk;
      logic csN;
      logic sdio;
   } spc_pins_s;
   typedef struct packed {
      logic sdioOut;
      logic sdioOe;
      logic serialOutPin;
      logic separateOutOe;
   } spc_drive_s;
   typedef struct packed {
      logic wr;
      logic [12:0] addr;
      logic [7:0] data;
   } spc_wreq_s;
endpackage

// [src/spc_sync.sv]
// two-flop synchroniser for the serial pins
module spc_sync #(
   parameter int W = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } spc_sy_s;
   spc_sy_s st_r;
   spc_sy_s st_nxt;
   // refused at elaboration: a zero-width synchroniser has nothing to carry
   if (W < 1)
   begin
      $error("spc_sync width must be positive");
   end
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
   end
   always_ff @(posedge mclk)
   begin
      if (rst) st_r <= '0;
      else if (ce) st_r <= st_nxt;
   end
   assign dout = st_r.s2;
endmodule

// [src/spc_port.sv]
// serial control port with configuration, identifier and readback select registers
// What the document asks of this block and its host
// [RULE1] host writes config upper nibble as bit-reversed mirror of lower nibble
// [RULE2] config bit 3 selects long 16-bit instructions; only long form is used
// [RULE3] config bit 2 holds all registers at defaults until host clears it; the code holds only the readback select copies, config keeps its written value
// [RULE4] bit 1 clear: msb first, address steps down; set: lsb first, steps up
// [RULE5] bit 0 clear: reads on bidirectional pin; set: reads on separate output pin
// [RULE6] address 0x003 returns a fixed read-only 8-bit variant identifier
// [RULE7] address readback_source_select bit 0 selects active copies instead of buffered for reads
// [RULE8] writes land in buffered copies; update command moves them to active; config writes also go straight to the active copy in the code
module spc_port (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire spc_pkg::spc_pins_s pins,
   output spc_pkg::spc_drive_s drive,
   output logic [7:0] activeConfig,
   output logic [7:0] activeReadSrc
);
   logic [2:0] syncd;
   spc_sync #(.W(3)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .din({pins.sclk, !pins.csN, pins.sdio}),
      .dout(syncd)
   );
   wire logic sclkS = syncd[2];
   // select travels inverted so cleared flops read as deselected right after reset
   wire logic csNS = !syncd[1];
   wire logic sdioS = syncd[0];
   typedef struct packed {
      spc_pkg::spc_state_e state;
      logic sclkPrev;
      logic [4:0] cnt;
      logic [15:0] instr;
      logic [7:0] shreg;
      logic isRead;
      logic [12:0] addr;
      logic [7:0] bufConfig;
      logic [7:0] bufReadSrc;
      logic [7:0] actConfig;
      logic [7:0] actReadSrc;
      logic outBit;
      logic driving;
   } spc_st_s;
   spc_st_s st_r;
   spc_st_s st_nxt;
   logic rise;
   logic fall;
   logic lsbFirst;
   logic [7:0] rdVal;
   logic [7:0] wrByte;
   logic [7:0] loadByte;
   assign rise = sclkS && !st_r.sclkPrev;
   assign fall = !sclkS && st_r.sclkPrev;
   // order applies from the active copy, which a config write sets at once, so a changed mode takes effect right after that write
   assign lsbFirst = st_r.actConfig[spc_pkg::CFG_LSB_BIT]; // RULE4
   always_comb
   begin
      rdVal = 8'h00;
      if (st_r.addr == spc_pkg::OFF_CONFIG)
      begin
         rdVal = st_r.actReadSrc[spc_pkg::RSRC_ACTIVE_BIT] ? st_r.actConfig
                                                              : st_r.bufConfig; // RULE7
      end
      else if (st_r.addr == spc_pkg::OFF_VARIANT)
      begin
         rdVal = spc_pkg::VARIANT_ID; // RULE6
      end
      else if (st_r.addr == spc_pkg::OFF_READSRC)
      begin
         rdVal = st_r.actReadSrc[spc_pkg::RSRC_ACTIVE_BIT] ? st_r.actReadSrc
                                                              : st_r.bufReadSrc; // RULE7
      end
   end
   always_comb
   begin
      wrByte = lsbFirst ? {sdioS, st_r.shreg[7:1]} : {st_r.shreg[6:0], sdioS}; // RULE4
      loadByte = rdVal;
      st_nxt = st_r;
      st_nxt.sclkPrev = sclkS;
      if (csNS)
      begin
         st_nxt.state = spc_pkg::ST_IDLE;
         st_nxt.driving = 1'b0;
         st_nxt.cnt = '0;
      end
      else
      begin
         case (st_r.state)
            spc_pkg::ST_IDLE:
            begin
               st_nxt.state = spc_pkg::ST_INSTR;
               st_nxt.cnt = '0;
            end
            spc_pkg::ST_INSTR:
            begin
               // only the long instruction is decoded; the short form is unsupported
               if (rise)
               begin
                  st_nxt.instr = lsbFirst ? {sdioS, st_r.instr[15:1]}
                                          : {st_r.instr[14:0], sdioS}; // RULE2
                  st_nxt.cnt = st_r.cnt + 5'd1;
                  if (st_r.cnt == 5'(spc_pkg::INSTR_BITS - 1))
                  begin
                     st_nxt.state = spc_pkg::ST_DATA;
                     st_nxt.cnt = '0;
                     if (lsbFirst)
                     begin
                        // lsb first: address arrives first, read flag is the last bit
                        st_nxt.isRead = sdioS;
                        st_nxt.addr = st_r.instr[13:1];
                     end
                     else
                     begin
                        st_nxt.isRead = st_r.instr[14];
                        st_nxt.addr = {st_r.instr[11:0], sdioS};
                     end
                  end
               end
            end
            spc_pkg::ST_DATA:
            begin
               if (st_r.isRead && st_r.cnt == 5'd0 && !st_r.driving)
               begin
                  st_nxt.shreg = loadByte;
                  st_nxt.outBit = lsbFirst ? loadByte[0] : loadByte[7];
                  st_nxt.driving = 1'b1;
               end
               else if (st_r.isRead && fall && st_r.cnt != 5'd0)
               begin
                  st_nxt.outBit = lsbFirst ? st_r.shreg[0] : st_r.shreg[7];
               end
               if (rise)
               begin
                  st_nxt.cnt = st_r.cnt + 5'd1;
                  if (st_r.isRead)
                  begin
                     st_nxt.shreg = lsbFirst ? {1'b0, st_r.shreg[7:1]}
                                             : {st_r.shreg[6:0], 1'b0};
                  end
                  else
                  begin
                     st_nxt.shreg = wrByte;
                  end
                  if (st_r.cnt == 5'd7)
                  begin
                     st_nxt.cnt = '0;
                     st_nxt.driving = 1'b0;
                     st_nxt.addr = lsbFirst ? st_r.addr + 13'd1 : st_r.addr - 13'd1; // RULE4
                     if (!st_r.isRead)
                     begin
                        // writes touch buffered copies, config writes the active copy as well; identifier ignores writes
                        if (st_r.addr == spc_pkg::OFF_CONFIG)
                        begin
                           st_nxt.bufConfig = wrByte; // RULE8
                           // soft reset and port modes act at once on the live copy
                           st_nxt.actConfig = wrByte; // RULE1
                        end
                        else if (st_r.addr == spc_pkg::OFF_READSRC)
                        begin
                           st_nxt.bufReadSrc = wrByte; // RULE8
                        end
                        else if (st_r.addr == spc_pkg::OFF_UPDATE && wrByte[spc_pkg::UPD_BIT])
                        begin
                           st_nxt.actConfig = st_r.bufConfig; // RULE8
                           st_nxt.actReadSrc = st_r.bufReadSrc; // RULE8
                        end
                     end
                  end
               end
            end
            default:
            begin
               st_nxt.state = spc_pkg::ST_IDLE;
            end
         endcase
      end
      // soft reset held: every register except the port configuration sits at default
      if (st_r.actConfig[spc_pkg::CFG_RST_BIT])
      begin
         st_nxt.bufReadSrc = spc_pkg::READSRC_RESET; // RULE3
         st_nxt.actReadSrc = spc_pkg::READSRC_RESET; // RULE3
      end
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_r <= '0;
         st_r.state <= spc_pkg::ST_IDLE;
         st_r.sclkPrev <= 1'b0;
         st_r.bufConfig <= spc_pkg::CONFIG_RESET;
         st_r.actConfig <= spc_pkg::CONFIG_RESET;
         st_r.bufReadSrc <= spc_pkg::READSRC_RESET;
         st_r.actReadSrc <= spc_pkg::READSRC_RESET;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
      end
   end
   always_comb
   begin
      drive.sdioOut = st_r.outBit;
      drive.serialOutPin = st_r.outBit;
      drive.sdioOe = st_r.driving && !st_r.actConfig[spc_pkg::CFG_SDO_BIT]; // RULE5
      drive.separateOutOe = st_r.driving && st_r.actConfig[spc_pkg::CFG_SDO_BIT]; // RULE5
   end
   assign activeConfig = st_r.actConfig;
   assign activeReadSrc = st_r.actReadSrc;
   sdo_mode_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
      !(drive.sdioOe && drive.separateOutOe)) else $error("both data pins driven");
   // watches the loaded shift register, so a broken load path trips it as well
   variant_fixed_a: assert property (@(posedge mclk) disable iff (rst) // RULE6
      (ce && !csNS && st_r.state == spc_pkg::ST_DATA && st_r.isRead && st_r.cnt == 5'd0
      && !st_r.driving && st_r.addr == spc_pkg::OFF_VARIANT)
      |=> st_r.shreg == spc_pkg::VARIANT_ID) else $error("variant identifier changed");
   readsrc_sel_a: assert property (@(posedge mclk) disable iff (rst) // RULE7
      (st_r.addr == spc_pkg::OFF_READSRC && !st_r.actReadSrc[spc_pkg::RSRC_ACTIVE_BIT])
      |-> rdVal == st_r.bufReadSrc) else $error("readback source wrong");
   soft_reset_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
      (ce && st_r.actConfig[spc_pkg::CFG_RST_BIT]) |=> st_r.actReadSrc == spc_pkg::READSRC_RESET)
      else $error("soft reset did not restore defaults");
   buffered_only_a: assert property (@(posedge mclk) disable iff (rst) // RULE8
      (ce && st_r.bufReadSrc != $past(st_r.bufReadSrc)) |-> $stable(st_r.actReadSrc)
      || st_r.actConfig[spc_pkg::CFG_RST_BIT])
      else $error("write reached active copy");
   addr_step_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
      (ce && !csNS && st_r.state == spc_pkg::ST_DATA && rise && st_r.cnt == 5'd7)
      |=> st_r.addr == ($past(lsbFirst) ? $past(st_r.addr) + 13'd1 : $past(st_r.addr) - 13'd1))
      else $error("address step wrong");
   long_instr_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
      (ce && !csNS && st_r.state == spc_pkg::ST_INSTR && rise && st_r.cnt == 5'd15)
      |=> st_r.state == spc_pkg::ST_DATA) else $error("instruction not 16 bits");
endmodule

// [test/spc_host.sv]
// host controller model that drives the serial control port
module spc_host (
   input wire logic mclk,
   input spc_pkg::spc_drive_s drive,
   output spc_pkg::spc_pins_s pins
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lsb = 1'b0;
   logic sdoMode = 1'b0;
   logic hostBit = 1'b1;
   logic sclk = 1'b0;
   logic csN = 1'b1;
   // a released line shows the toggling host bit so a stale bit cannot pass for read data
   assign pins = {sclk, csN, drive.sdioOe ? drive.sdioOut : hostBit};
   // entered just after a clock edge; one bit spans 8 clocks, a 200 ns link period
   task automatic clockBit(input logic b, input logic rd, output logic r);
      hostBit = rd ? ~hostBit : b;
      repeat (4) @(posedge mclk);
      #1;
      r = sdoMode ? (drive.separateOutOe ? drive.serialOutPin : hostBit) : pins.sdio;
      sclk = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      sclk = 1'b0;
   endtask
   task automatic xfer(input logic rd, input logic [12:0] addr, input int n,
      input logic [15:0] wd, output logic [15:0] rdat);
      logic [15:0] ins;
      logic r;
      ins = {rd, ((n == 2) ? 2'b01 : 2'b00), addr};
      rdat = '0;
      @(posedge mclk);
      #1;
      csN = 1'b0;
      for (int i = 0; i < 16; i++)
         clockBit(ins[lsb ? i : 15 - i], 1'b0, r);
      for (int k = 0; k < n; k++)
         for (int i = 0; i < 8; i++)
         begin
            clockBit(wd[8 * k + (lsb ? i : 7 - i)], rd, r);
            rdat[8 * k + (lsb ? i : 7 - i)] = r;
         end
      repeat (4) @(posedge mclk);
      #1;
      csN = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
   endtask
endmodule

// [test/spc_port_bench.sv]
// self-checking bench for the serial port configuration registers
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin nMismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module spc_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   spc_pkg::spc_pins_s pins;
   spc_pkg::spc_drive_s drive;
   logic [7:0] activeConfig;
   logic [7:0] activeReadSrc;
   logic [15:0] rv;
   logic [7:0] id;
   int nMismatch = 0;
   int nCompared = 0;
   int cycles = 0;
   int badOe = 0;
   logic sawSep = 1'b0;
   spc_port dut (.mclk(mclk), .rst(rst), .ce(1'b1), .pins(pins), .drive(drive),
      .activeConfig(activeConfig), .activeReadSrc(activeReadSrc));
   spc_host host (.mclk(mclk), .drive(drive), .pins(pins));
   initial
   begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", nMismatch, nCompared);
      if (nMismatch == 0 && nCompared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [15:0] x;
      host.xfer(1'b0, a, 1, {8'h00, d}, x);
   endtask
   task automatic rd(input logic [12:0] a, input int n);
      host.xfer(1'b1, a, n, 16'h0000, rv);
   endtask
   // the two output enables must follow the active port mode and never overlap
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         nMismatch++;
         wrap_up();
      end
      if (!rst && (drive.separateOutOe && !activeConfig[0] || drive.sdioOe && activeConfig[0]))
         badOe <= badOe + 1;
      if (drive.separateOutOe)
         sawSep <= 1'b1;
   end
   initial
   begin
      id = spc_pkg::VARIANT_ID;
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      rd(spc_pkg::OFF_CONFIG, 1);
      `CHK(rv[7:0], spc_pkg::CONFIG_RESET)
      `CHK(activeReadSrc, 8'h00)
      wr(spc_pkg::OFF_VARIANT, ~id);
      rd(spc_pkg::OFF_VARIANT, 1);
      `CHK(rv[7:0], id)
      rd(13'h0010, 1);
      `CHK(rv[7:0], 8'h00)
      wr(spc_pkg::OFF_READSRC, 8'h01);
      `CHK(activeReadSrc, 8'h00)
      rd(spc_pkg::OFF_READSRC, 1);
      `CHK(rv[7:0], 8'h01)
      wr(spc_pkg::OFF_UPDATE, 8'h01);
      `CHK(activeReadSrc, 8'h01)
      wr(spc_pkg::OFF_READSRC, 8'h00);
      rd(spc_pkg::OFF_READSRC, 1);
      `CHK(rv[7:0], 8'h01)
      wr(spc_pkg::OFF_UPDATE, 8'h01);
      rd(spc_pkg::OFF_READSRC, 2);
      `CHK(rv, {id, 8'h00})
      wr(spc_pkg::OFF_CONFIG, 8'h99);
      host.sdoMode = 1'b1;
      rd(spc_pkg::OFF_VARIANT, 1);
      `CHK(rv[7:0], id)
      `CHK(sawSep, 1'b1)
      wr(spc_pkg::OFF_CONFIG, 8'h18);
      host.sdoMode = 1'b0;
      wr(spc_pkg::OFF_CONFIG, 8'h5a);
      host.lsb = 1'b1;
      rd(spc_pkg::OFF_VARIANT, 2);
      `CHK(rv, {8'h00, id})
      wr(spc_pkg::OFF_CONFIG, 8'h18);
      host.lsb = 1'b0;
      `CHK(activeConfig, 8'h18)
      wr(spc_pkg::OFF_READSRC, 8'h01);
      wr(spc_pkg::OFF_UPDATE, 8'h01);
      wr(spc_pkg::OFF_CONFIG, 8'h3c);
      `CHK(activeReadSrc, 8'h00)
      `CHK(activeConfig, 8'h3c)
      // a write while soft reset is held must not stick
      wr(spc_pkg::OFF_READSRC, 8'h01);
      wr(spc_pkg::OFF_CONFIG, 8'h18);
      rd(spc_pkg::OFF_READSRC, 1);
      `CHK(rv[7:0], 8'h00)
      // mid-run reset must bring the port back to msb first and long instructions
      wr(spc_pkg::OFF_CONFIG, 8'h5a);
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      `CHK(activeConfig, spc_pkg::CONFIG_RESET)
      `CHK(badOe, 0)
      wrap_up();
   end
endmodule
